// ===== core/dmh_cfg.svh
// Register indices, field positions, reset values and encodings for dial and handshake control
// Included by the package and every design file; definitions only
`ifndef DMH_CFG_SVH
`define DMH_CFG_SVH

`define DMH_AW              4
`define DMH_DW              16
`define DMH_A_CONFIG        4'h0
`define DMH_A_HOST_CTRL     4'h1
`define DMH_A_HOST_STAT     4'h2
`define DMH_A_TONE_STAT     4'h3
`define DMH_A_TRAIN_CTRL    4'h4
`define DMH_A_SEQ_FIRST     4'h5
`define DMH_A_SEQ_SECOND    4'h6
`define DMH_A_SEQ_THIRD     4'h7
`define DMH_A_HIGH_LEVEL    4'h8
`define DMH_A_LOW_LEVEL     4'h9
`define DMH_A_MODEM_STAT    4'hA

`define DMH_MODE_LSB        0
`define DMH_MODE_MSB        6
`define DMH_MANUAL_BIT      10
`define DMH_MODE_STANDBY    7'h00
`define DMH_MODE_DIAL       7'h03
`define DMH_MODE_ANSWER     7'h08
`define DMH_MODE_ORIGINATE  7'h09

`define DMH_HOOK_REQ_BIT    0
`define DMH_SEND_REQ_BIT    3
`define DMH_BUSY_BIT        4
`define DMH_SEIZED_BIT      2

`define DMH_DIGIT_LSB       0
`define DMH_DIGIT_MSB       3
`define DMH_TIMED_BIT       4
`define DMH_TONE_TYPE_BIT   7
`define DMH_TONE_STAT_RST   16'h0080

`define DMH_TXSEL_LSB       0
`define DMH_TXSEL_MSB       2
`define DMH_SIXTEEN_BIT     3
`define DMH_DET_PLAIN_BIT   5
`define DMH_DET_SYNC_BIT    6
`define DMH_DET_SCRAM_BIT   7

`define DMH_PULSES_FOR_ZERO 4'hA
`define DMH_CLK_HZ          125000000
`define DMH_TICK_HZ         9600
`define DMH_ZERO16          16'h0000

`endif

// ===== core/dmh_pkg.sv
// Types shared by the dial and handshake control block
// Assumes dmh_cfg.svh is on the include path
`include "dmh_cfg.svh"
package dmh_pkg;
  typedef logic [`DMH_DW-1:0] dmh_word_t;

  typedef enum logic [2:0] {
    DMH_IDLE  = 3'b000,
    DMH_TONE  = 3'b001,
    DMH_GAP   = 3'b010,
    DMH_BREAK = 3'b011,
    DMH_MAKE  = 3'b100,
    DMH_PAUSE = 3'b101
  } dmh_seq_e;

  typedef struct packed {
    dmh_word_t t_first;
    dmh_word_t t_second;
    dmh_word_t t_third;
  } dmh_timers_s;

  typedef struct packed {
    logic busy;
    logic tone_on;
    logic line_break;
  } dmh_seq_stat_s;
endpackage

// ===== core/dmh_dial_seq.sv
// Timed tone and pulse dial sequencer, paced by a sample-rate tick
// Assumes start is a one-cycle pulse and timers are stable while busy
`timescale 1ns/100ps
`include "dmh_cfg.svh"
module dmh_dial_seq (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               tick,
  input  wire logic               start,
  input  wire logic               abort,
  input  wire logic               pulse_mode,
  input  wire logic [3:0]         digit,
  input  wire dmh_pkg::dmh_timers_s timers,
  output dmh_pkg::dmh_seq_stat_s  stat
);
  import dmh_pkg::*;

  dmh_seq_e  state_reg, state_next;
  dmh_word_t cnt_reg, cnt_next;
  logic [3:0] pulses_reg, pulses_next;

  wire expire  = tick && (cnt_reg <= 16'h0001);
  wire [3:0] pulse_total = (digit == 4'h0) ? `DMH_PULSES_FOR_ZERO : digit;

  always_comb begin
    state_next  = state_reg;
    cnt_next    = (tick && cnt_reg != `DMH_ZERO16) ? cnt_reg - 16'h0001 : cnt_reg;
    pulses_next = pulses_reg;
    case (state_reg)
      DMH_IDLE: begin
        if (start && pulse_mode) begin
          state_next  = DMH_BREAK;
          cnt_next    = timers.t_second;
          pulses_next = pulse_total;
        end else if (start) begin
          state_next = DMH_TONE;
          cnt_next   = timers.t_first;
        end
      end
      DMH_TONE: begin
        if (expire) begin
          state_next = DMH_GAP;
          cnt_next   = timers.t_second;
        end
      end
      DMH_GAP: begin
        if (expire) begin
          state_next = DMH_IDLE;
        end
      end
      DMH_BREAK: begin
        if (expire) begin
          state_next  = DMH_MAKE;
          cnt_next    = timers.t_first;
          pulses_next = pulses_reg - 4'h1;
        end
      end
      DMH_MAKE: begin
        if (expire && pulses_reg == 4'h0) begin
          state_next = DMH_PAUSE;
          cnt_next   = timers.t_third;
        end else if (expire) begin
          state_next = DMH_BREAK;
          cnt_next   = timers.t_second;
        end
      end
      DMH_PAUSE: begin
        if (expire) begin
          state_next = DMH_IDLE;
        end
      end
      default: begin
        state_next = DMH_IDLE;
      end
    endcase
    if (abort) begin
      state_next = DMH_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg  <= DMH_IDLE;
      cnt_reg    <= `DMH_ZERO16;
      pulses_reg <= 4'h0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      pulses_reg <= pulses_next;
    end
  end

  assign stat.busy       = (state_reg != DMH_IDLE);
  assign stat.tone_on    = (state_reg == DMH_TONE);
  assign stat.line_break = (state_reg == DMH_BREAK);
endmodule // dmh_dial_seq

// ===== core/dmh_top.sv
// Dial and manual handshake control: host register file, dial sequencing, signal selection
// Assumes a single-cycle host strobe port; detector and tone generator sit outside
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/100ps
`include "dmh_cfg.svh"
module dmh_top #(
  parameter int unsigned TICK_DIV = `DMH_CLK_HZ / `DMH_TICK_HZ
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic [`DMH_AW-1:0]  reg_addr,
  input  wire dmh_pkg::dmh_word_t  reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output dmh_pkg::dmh_word_t       reg_rdata,
  input  wire logic                det_plain_ones,
  input  wire logic                det_sync_pattern,
  input  wire logic                det_scrambled_ones,
  input  wire logic                rx_link_ready,
  input  wire logic                rx_data_in,
  output logic                     rx_data_out,
  output logic                     line_seized_flag,
  output logic                     dtmf_enable,
  output logic [3:0]               dtmf_digit,
  output dmh_pkg::dmh_word_t       dtmf_high_level,
  output dmh_pkg::dmh_word_t       dtmf_low_level,
  output logic                     manual_handshake,
  output logic [2:0]               transmit_signal_select,
  output logic                     sixteen_point_select
);
  import dmh_pkg::*;

  generate
    if (TICK_DIV < 2) begin : g_bad_div
      $error("TICK_DIV must be at least 2");
    end
  endgenerate

  localparam int unsigned DIV_W = $clog2(TICK_DIV);

  dmh_word_t config_reg, host_ctrl_reg, tone_stat_reg, train_reg;
  dmh_word_t seq_first_reg, seq_second_reg, seq_third_reg;
  dmh_word_t high_level_reg, low_level_reg;
  dmh_word_t rdata_reg, rdata_next;
  logic [DIV_W-1:0] div_reg;
  logic [2:0]       det_reg;
  logic             send_req_d_reg;
  logic             hold_mark_reg;
  logic             rx_data_reg;
  logic             seized_reg;
  logic             dtmf_en_reg;
  dmh_seq_stat_s    seq_stat;
  dmh_timers_s      timers;

  // Write decode
  wire wr_config = reg_wr && (reg_addr == `DMH_A_CONFIG);
  wire wr_hctrl  = reg_wr && (reg_addr == `DMH_A_HOST_CTRL);
  wire wr_tone   = reg_wr && (reg_addr == `DMH_A_TONE_STAT);
  wire wr_train  = reg_wr && (reg_addr == `DMH_A_TRAIN_CTRL);
  wire wr_seq1   = reg_wr && (reg_addr == `DMH_A_SEQ_FIRST);
  wire wr_seq2   = reg_wr && (reg_addr == `DMH_A_SEQ_SECOND);
  wire wr_seq3   = reg_wr && (reg_addr == `DMH_A_SEQ_THIRD);
  wire wr_high   = reg_wr && (reg_addr == `DMH_A_HIGH_LEVEL);
  wire wr_low    = reg_wr && (reg_addr == `DMH_A_LOW_LEVEL);

  // Control fields
  wire [6:0] mode       = config_reg[`DMH_MODE_MSB:`DMH_MODE_LSB];
  wire [6:0] wr_mode    = reg_wdata[`DMH_MODE_MSB:`DMH_MODE_LSB];
  wire       dial_mode  = (mode == `DMH_MODE_DIAL);
  wire       send_req   = host_ctrl_reg[`DMH_SEND_REQ_BIT];
  wire       hook_req   = host_ctrl_reg[`DMH_HOOK_REQ_BIT];
  wire       tone_type  = tone_stat_reg[`DMH_TONE_TYPE_BIT];
  wire       timed_sel  = tone_stat_reg[`DMH_TIMED_BIT];
  wire       pulse_mode = !tone_type;
  wire       timed_run  = timed_sel || pulse_mode;
  wire       send_rise  = send_req && !send_req_d_reg;
  wire       seq_start  = dial_mode && timed_run && send_rise && !seq_stat.busy;
  wire       tick       = (div_reg == DIV_W'(TICK_DIV - 1));
  wire       cont_tone  = dial_mode && tone_type && !timed_sel && send_req;
  wire       answer_cfg = wr_config && ((wr_mode == `DMH_MODE_ANSWER) || (wr_mode == `DMH_MODE_ORIGINATE));
  wire       seized_nxt = (hook_req || seq_stat.busy) && !seq_stat.line_break;

  assign timers.t_first  = seq_first_reg;
  assign timers.t_second = seq_second_reg;
  assign timers.t_third  = seq_third_reg;

  // Sample-rate divider
  always_ff @(posedge clk_sys) begin
    if (rst || tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // Host-written registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      config_reg     <= `DMH_ZERO16;
      host_ctrl_reg  <= `DMH_ZERO16;
      tone_stat_reg  <= `DMH_TONE_STAT_RST;
      seq_first_reg  <= `DMH_ZERO16;
      seq_second_reg <= `DMH_ZERO16;
      seq_third_reg  <= `DMH_ZERO16;
      high_level_reg <= `DMH_ZERO16;
      low_level_reg  <= `DMH_ZERO16;
    end else begin
      if (wr_config) config_reg     <= reg_wdata;
      if (wr_hctrl)  host_ctrl_reg  <= reg_wdata;
      if (wr_tone)   tone_stat_reg  <= reg_wdata;
      if (wr_seq1)   seq_first_reg  <= reg_wdata;
      if (wr_seq2)   seq_second_reg <= reg_wdata;
      if (wr_seq3)   seq_third_reg  <= reg_wdata;
      if (wr_high)   high_level_reg <= reg_wdata;
      if (wr_low)    low_level_reg  <= reg_wdata;
    end
  end

  // Training control: host bits only, detect bits come from det_reg
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      train_reg <= `DMH_ZERO16;
    end else if (wr_train) begin
      train_reg <= reg_wdata;
    end
  end

  // Registered remote signal detect flags
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_det
      wire det_in = (gi == 0) ? det_plain_ones : ((gi == 1) ? det_sync_pattern : det_scrambled_ones);
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          det_reg[gi] <= 1'b0;
        end else begin
          det_reg[gi] <= det_in;
        end
      end
    end
  endgenerate

  dmh_dial_seq u_seq (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .tick       (tick),
    .start      (seq_start),
    .abort      (!dial_mode),
    .pulse_mode (pulse_mode),
    .digit      (tone_stat_reg[`DMH_DIGIT_MSB:`DMH_DIGIT_LSB]),
    .timers     (timers),
    .stat       (seq_stat)
  );

  // Line and receive side state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      send_req_d_reg <= 1'b0;
      hold_mark_reg  <= 1'b0;
      rx_data_reg    <= 1'b1;
      seized_reg     <= 1'b0;
      dtmf_en_reg    <= 1'b0;
    end else begin
      send_req_d_reg <= send_req;
      if (answer_cfg) begin
        hold_mark_reg <= 1'b1;
      end else if (rx_link_ready) begin
        hold_mark_reg <= 1'b0;
      end
      rx_data_reg <= (hold_mark_reg || answer_cfg) ? 1'b1 : rx_data_in;
      seized_reg  <= seized_nxt;
      dtmf_en_reg <= cont_tone || (seq_stat.tone_on && tone_type);
    end
  end

  // Read mux, data one cycle after the strobe
  always_comb begin
    rdata_next = `DMH_ZERO16;
    if (reg_addr == `DMH_A_CONFIG) begin
      rdata_next = config_reg;
    end else if (reg_addr == `DMH_A_HOST_CTRL) begin
      rdata_next = host_ctrl_reg;
    end else if (reg_addr == `DMH_A_HOST_STAT) begin
      rdata_next[`DMH_BUSY_BIT] = seq_stat.busy;
    end else if (reg_addr == `DMH_A_TONE_STAT) begin
      rdata_next = tone_stat_reg;
    end else if (reg_addr == `DMH_A_TRAIN_CTRL) begin
      rdata_next = train_reg;
      rdata_next[`DMH_DET_PLAIN_BIT] = det_reg[0];
      rdata_next[`DMH_DET_SYNC_BIT]  = det_reg[1];
      rdata_next[`DMH_DET_SCRAM_BIT] = det_reg[2];
    end else if (reg_addr == `DMH_A_SEQ_FIRST) begin
      rdata_next = seq_first_reg;
    end else if (reg_addr == `DMH_A_SEQ_SECOND) begin
      rdata_next = seq_second_reg;
    end else if (reg_addr == `DMH_A_SEQ_THIRD) begin
      rdata_next = seq_third_reg;
    end else if (reg_addr == `DMH_A_HIGH_LEVEL) begin
      rdata_next = high_level_reg;
    end else if (reg_addr == `DMH_A_LOW_LEVEL) begin
      rdata_next = low_level_reg;
    end else if (reg_addr == `DMH_A_MODEM_STAT) begin
      rdata_next[`DMH_SEIZED_BIT] = seized_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_reg <= `DMH_ZERO16;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= `DMH_ZERO16;
    end
  end

  assign reg_rdata              = rdata_reg;
  assign rx_data_out            = rx_data_reg;
  assign line_seized_flag       = seized_reg;
  assign dtmf_enable            = dtmf_en_reg;
  assign dtmf_digit             = tone_stat_reg[`DMH_DIGIT_MSB:`DMH_DIGIT_LSB];
  assign dtmf_high_level        = high_level_reg;
  assign dtmf_low_level         = low_level_reg;
  assign manual_handshake       = config_reg[`DMH_MANUAL_BIT];
  // Own handshake engine lives outside; it is told to stand aside by manual_handshake
  assign transmit_signal_select = config_reg[`DMH_MANUAL_BIT] ?
                                  train_reg[`DMH_TXSEL_MSB:`DMH_TXSEL_LSB] : 3'h0;
  assign sixteen_point_select   = train_reg[`DMH_SIXTEEN_BIT];
endmodule // dmh_top

// ===== tb/dmh_properties.sv
// Concurrent checks on the dial and handshake block ports
// Bound to dmh_top; one clock, synchronous active-high reset
`timescale 1ns/100ps
`include "dmh_cfg.svh"
module dmh_properties (
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire logic [`DMH_AW-1:0] reg_addr,
  input wire dmh_pkg::dmh_word_t reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire dmh_pkg::dmh_word_t reg_rdata,
  input wire logic               rx_link_ready,
  input wire logic               rx_data_in,
  input wire logic               rx_data_out,
  input wire logic               line_seized_flag,
  input wire logic               dtmf_enable,
  input wire logic [3:0]         dtmf_digit,
  input wire logic               manual_handshake,
  input wire logic [2:0]         transmit_signal_select,
  input wire logic               sixteen_point_select
);
  import dmh_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic [6:0] mode_seen_reg;
  wire        cfg_wr   = reg_wr && reg_addr == `DMH_A_CONFIG;
  wire        train_wr = reg_wr && reg_addr == `DMH_A_TRAIN_CTRL;
  wire        hold_wr  = cfg_wr && (reg_wdata[6:0] == `DMH_MODE_ANSWER || reg_wdata[6:0] == `DMH_MODE_ORIGINATE);

  always_ff @(posedge clk_sys) begin
    if (rst) mode_seen_reg <= 7'h00;
    else if (cfg_wr) mode_seen_reg <= reg_wdata[6:0];
  end

  sequence s_out_of_dial;
    (mode_seen_reg != `DMH_MODE_DIAL) [*3];
  endsequence
  sequence s_link_up;
    (rx_link_ready && !hold_wr) [*3];
  endsequence

  chk_dial_quiet: assert property (s_out_of_dial |-> !dtmf_enable)
    else $error("tone on outside dial mode");
  chk_rd_stands: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  chk_mark_hold: assert property (hold_wr ##1 !rx_link_ready |=> rx_data_out)
    else $error("received data not held at mark");
  chk_link_pass: assert property (s_link_up |=> rx_data_out == $past(rx_data_in))
    else $error("received data not passed");
  chk_seized_mirror: assert property (reg_rd && reg_addr == `DMH_A_MODEM_STAT
    |=> reg_rdata[`DMH_SEIZED_BIT] == $past(line_seized_flag)) else $error("seized status differs from pin");
  chk_txsel_gate: assert property (!manual_handshake |-> transmit_signal_select == 3'h0)
    else $error("signal selected without manual control");
  chk_txsel_write: assert property (train_wr && manual_handshake
    |=> transmit_signal_select == $past(reg_wdata[2:0])) else $error("signal select not applied");
  chk_sixteen_echo: assert property (train_wr |=> sixteen_point_select == $past(reg_wdata[3]))
    else $error("sixteen point select not applied");
  chk_digit_out: assert property (reg_wr && reg_addr == `DMH_A_TONE_STAT
    |=> dtmf_digit == $past(reg_wdata[3:0])) else $error("digit not applied");
endmodule // dmh_properties

bind dmh_top dmh_properties u_dmh_properties (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_link_ready(rx_link_ready), .rx_data_in(rx_data_in),
  .rx_data_out(rx_data_out), .line_seized_flag(line_seized_flag), .dtmf_enable(dtmf_enable),
  .dtmf_digit(dtmf_digit), .manual_handshake(manual_handshake),
  .transmit_signal_select(transmit_signal_select), .sixteen_point_select(sixteen_point_select)
);

// ===== tb/dmh_remote.sv
// Far-end model: remote modem as seen through the receiver front end
// Commanded by tb; detect flags and link state are registered levels
`timescale 1ns/100ps
module dmh_remote (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [1:0] sig_sel,
  input  wire logic       link_up,
  output logic            det_plain_ones,
  output logic            det_sync_pattern,
  output logic            det_scrambled_ones,
  output logic            rx_link_ready,
  output logic            rx_data_in
);
  // Data toggles every cycle so a forced or stale bit shows
  always_ff @(posedge clk_sys) begin
    det_plain_ones     <= !rst && sig_sel == 2'h1;
    det_sync_pattern   <= !rst && sig_sel == 2'h2;
    det_scrambled_ones <= !rst && sig_sel == 2'h3;
    rx_link_ready      <= !rst && link_up;
    rx_data_in         <= !rst && !rx_data_in;
  end
endmodule // dmh_remote

// ===== tb/tb.sv
// Self-checking bench for the dial and handshake block
// Assumes dmh_cfg.svh on the include path; host tasks drive the register port
`timescale 1ns/100ps
`include "dmh_cfg.svh"
module tb;
  import dmh_pkg::*;
  logic       clk_sys, rst, reg_wr, reg_rd, link_up, s;
  logic [3:0] reg_addr, dtmf_digit;
  logic [1:0] sig_sel;
  logic [2:0] transmit_signal_select;
  dmh_word_t  reg_wdata, reg_rdata, d, dtmf_high_level, dtmf_low_level;
  logic       rx_data_out, line_seized_flag, dtmf_enable, manual_handshake, sixteen_point_select;
  logic       det_plain_ones, det_sync_pattern, det_scrambled_ones, rx_link_ready, rx_data_in;
  int         mismatches, comparisons, falls, on_cnt, i;

  dmh_top #(.TICK_DIV(4)) u_dmh_top (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .det_plain_ones(det_plain_ones),
    .det_sync_pattern(det_sync_pattern), .det_scrambled_ones(det_scrambled_ones),
    .rx_link_ready(rx_link_ready), .rx_data_in(rx_data_in), .rx_data_out(rx_data_out),
    .line_seized_flag(line_seized_flag), .dtmf_enable(dtmf_enable), .dtmf_digit(dtmf_digit),
    .dtmf_high_level(dtmf_high_level), .dtmf_low_level(dtmf_low_level), .manual_handshake(manual_handshake),
    .transmit_signal_select(transmit_signal_select), .sixteen_point_select(sixteen_point_select));
  dmh_remote u_dmh_remote (
    .clk_sys(clk_sys), .rst(rst), .sig_sel(sig_sel), .link_up(link_up),
    .det_plain_ones(det_plain_ones), .det_sync_pattern(det_sync_pattern),
    .det_scrambled_ones(det_scrambled_ones), .rx_link_ready(rx_link_ready), .rx_data_in(rx_data_in));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(negedge line_seized_flag) falls++;
  always @(posedge clk_sys) if (dtmf_enable === 1'b1) on_cnt++;

  task results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input dmh_word_t v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [3:0] a, output dmh_word_t v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task wait_idle;
    int k;
    for (k = 0; k < 300; k++) begin
      rd(`DMH_A_HOST_STAT, d);
      if (d[`DMH_BUSY_BIT] === 1'b0) return;
    end
    mismatches++;
    results;
  endtask

  task t_regs;
    rd(`DMH_A_TONE_STAT, d); chk(d, 16'h0080);
    rd(4'hB, d); chk(d, 16'h0000);
    wr(`DMH_A_HOST_STAT, 16'hFFFF);
    rd(`DMH_A_HOST_STAT, d); chk(d, 16'h0000);
    wr(`DMH_A_HIGH_LEVEL, 16'h4000);
    wr(`DMH_A_LOW_LEVEL, 16'h3800);
    chk(dtmf_high_level, 16'h4000);
    chk(dtmf_low_level, 16'h3800);
  endtask
  task t_cont;
    wr(`DMH_A_HOST_CTRL, 16'h0008);
    repeat (4) @(posedge clk_sys);
    #1 chk(dtmf_enable, 16'h0000);
    wr(`DMH_A_HOST_CTRL, 16'h0000);
    wr(`DMH_A_CONFIG, 16'h0003);
    wr(`DMH_A_TONE_STAT, 16'h008B);
    wr(`DMH_A_HOST_CTRL, 16'h0008);
    repeat (2) @(posedge clk_sys);
    #1 chk(dtmf_enable, 16'h0001);
    chk(dtmf_digit, 16'h000B);
    wr(`DMH_A_HOST_CTRL, 16'h0000);
    repeat (2) @(posedge clk_sys);
    #1 chk(dtmf_enable, 16'h0000);
  endtask
  task t_timed;
    wr(`DMH_A_TONE_STAT, 16'h0095);
    wr(`DMH_A_SEQ_FIRST, 16'h0001);
    wr(`DMH_A_SEQ_SECOND, 16'h0001);
    on_cnt = 0;
    wr(`DMH_A_HOST_CTRL, 16'h0008);
    rd(`DMH_A_HOST_STAT, d); chk(d[`DMH_BUSY_BIT], 16'h0001);
    wait_idle;
    chk(dtmf_enable, 16'h0000);
    chk(on_cnt != 0, 16'h0001);
    wr(`DMH_A_HOST_CTRL, 16'h0000);
  endtask
  task t_pulse(input logic [3:0] dg, input int n);
    wr(`DMH_A_TONE_STAT, {12'h001, dg});
    wr(`DMH_A_CONFIG, 16'h0003);
    wr(`DMH_A_SEQ_FIRST, 16'h0002);
    wr(`DMH_A_SEQ_SECOND, 16'h0002);
    wr(`DMH_A_SEQ_THIRD, 16'h0002);
    wr(`DMH_A_HOST_CTRL, 16'h0001);
    rd(`DMH_A_MODEM_STAT, d); chk(d[`DMH_SEIZED_BIT], 16'h0001);
    falls = 0;
    wr(`DMH_A_HOST_CTRL, 16'h0009);
    wait_idle;
    chk(falls, n);
    chk(line_seized_flag, 16'h0001);
    wr(`DMH_A_HOST_CTRL, 16'h0000);
    wr(`DMH_A_CONFIG, 16'h0000);
  endtask
  task t_manual;
    wr(`DMH_A_TRAIN_CTRL, 16'h0005);
    chk(transmit_signal_select, 16'h0000);
    wr(`DMH_A_CONFIG, 16'h4409);
    chk(manual_handshake, 16'h0001);
    for (i = 0; i < 8; i++) begin
      wr(`DMH_A_TRAIN_CTRL, 16'(i));
      chk(transmit_signal_select, 16'(i));
    end
    wr(`DMH_A_TRAIN_CTRL, 16'h0008);
    chk(sixteen_point_select, 16'h0001);
    for (i = 1; i < 4; i++) begin
      @(posedge clk_sys) sig_sel <= 2'(i);
      repeat (3) @(posedge clk_sys);
      rd(`DMH_A_TRAIN_CTRL, d); chk(d[7:5], 16'(1 << (i - 1)));
    end
    repeat (4) begin
      @(posedge clk_sys);
      #1 chk(rx_data_out, 16'h0001);
    end
    @(posedge clk_sys) link_up <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 s = rx_data_out;
    @(posedge clk_sys);
    #1 chk(rx_data_out, !s);
    wr(`DMH_A_CONFIG, 16'h0000);
    wr(`DMH_A_CONFIG, 16'h0008);
    chk(rx_data_out, 16'h0001);
    wr(`DMH_A_CONFIG, 16'h0000);
  endtask

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    sig_sel = 2'h0;
    link_up = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs;
    t_cont;
    t_timed;
    t_pulse(4'h2, 2);
    t_pulse(4'h0, 10);
    t_manual;
    results;
  end
endmodule // tb
